// ==== core/lmp_pkg.sv ====
package lmp_pkg;
  localparam logic [7:0] ADDR_PICTURE = 8'h00;
  localparam logic [7:0] ADDR_MOVIE = 8'h01;
  localparam logic [7:0] ADDR_PLAYBACK = 8'h02;
  localparam logic [7:0] ADDR_HOLD_SHIFT = 8'h03;
  localparam logic [7:0] ADDR_REPEAT_SCAN = 8'h04;
  localparam logic [7:0] ADDR_CURRENT = 8'h05;
  localparam logic [7:0] RST_PICTURE = 8'h00;
  localparam logic [7:0] RST_MOVIE = 8'h00;
  localparam logic [7:0] RST_PLAYBACK = 8'h00;
  localparam logic [7:0] RST_HOLD_SHIFT = 8'h00;
  localparam logic [7:0] RST_REPEAT_SCAN = 8'h20;
  localparam logic [7:0] RST_CURRENT = 8'h00;
  localparam int BIT_BLINK_OFF = 7;
  localparam int BIT_END_LAST = 6;
  localparam int BIT_FADE = 7;
  localparam int BIT_DIR = 6;
  localparam int BIT_BLOCK = 5;
  localparam int BIT_SCROLL = 4;
  localparam int BIT_BLINK_SLOW = 4;
  localparam int BIT_PIC_BLINK = 7;
  localparam int BIT_SHOW = 6;
  localparam logic [2:0] LOOP_ENDLESS = 3'h7;
  localparam logic [2:0] LOOP_INVALID = 3'h0;
  localparam logic [3:0] SCAN_ALL = 4'hb;
  localparam int CLK_HZ = 40000000;
  localparam int SCAN_ALL_HZ = 430;
  localparam int SEGMENTS = 12;
  // Cycles for one segment slot so that twelve slots refresh at 430 Hz.
  localparam int SEG_CYC = CLK_HZ / (SCAN_ALL_HZ * SEGMENTS);
  localparam int HOLD_STEP_US = 32500;
  localparam int HOLD_STEP_CYC = HOLD_STEP_US * (CLK_HZ / 1000000);
  localparam int BLINK_FAST_MS = 1500;
  localparam int BLINK_SLOW_MS = 3000;
  localparam int BLINK_FAST_CYC = BLINK_FAST_MS * (CLK_HZ / 1000);
  localparam int BLINK_SLOW_CYC = BLINK_SLOW_MS * (CLK_HZ / 1000);
  typedef enum logic [1:0] {
    LMP_IDLE = 2'b00,
    LMP_SHOW = 2'b01,
    LMP_HOLD = 2'b10,
    LMP_DONE = 2'b11
  } lmp_state_t;
endpackage

// ==== core/lmp_scan.sv ====
`timescale 1ns/1ps
module lmp_scan #(
  parameter int SEG_CYC = lmp_pkg::SEG_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] scan_limit,
  output logic [3:0] segment,
  output logic frame_tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [3:0] seg;
    logic tick;
  } lmp_scan_st_t;
  lmp_scan_st_t st_ff;
  lmp_scan_st_t nxt_st;
  logic [3:0] lim;
  always_comb begin
    lim = (scan_limit > lmp_pkg::SCAN_ALL) ? lmp_pkg::SCAN_ALL : scan_limit;
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == 16'(SEG_CYC - 1)) begin
      nxt_st.cnt = 16'h0000;
      // A frame only covers segment zero up to the limit, so fewer segments refresh faster.
      if (st_ff.seg >= lim) begin
        nxt_st.seg = 4'h0;
        nxt_st.tick = 1'b1;
      end else begin
        nxt_st.seg = st_ff.seg + 4'h1;
      end
    end else begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign segment = st_ff.seg;
  assign frame_tick = st_ff.tick;
  a_seg_bound: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff.tick |-> $past(st_ff.seg) >= $past(lim)) else $error("Frame ended early.");
endmodule

// ==== core/lmp_ctrl.sv ====
`timescale 1ns/1ps
module lmp_ctrl #(
  parameter int HOLD_STEP_CYC = lmp_pkg::HOLD_STEP_CYC,
  parameter int BLINK_FAST_CYC = lmp_pkg::BLINK_FAST_CYC,
  parameter int BLINK_SLOW_CYC = lmp_pkg::BLINK_SLOW_CYC,
  parameter int SEG_CYC = lmp_pkg::SEG_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [5:0] frame_index,
  output logic movie_active,
  output logic picture_active,
  output logic blink_on,
  output logic fade_en,
  output logic scroll_en,
  output logic scroll_left,
  output logic scroll_block,
  output logic [3:0] segment_sel,
  output logic [7:0] led_current,
  output logic movie_done
);
  typedef struct packed {
    logic [7:0] picture;
    logic [7:0] movie;
    logic [7:0] playback;
    logic [7:0] hold_shift;
    logic [7:0] repeat_scan;
    logic [7:0] current;
    lmp_pkg::lmp_state_t state;
    logic [5:0] pos;
    logic [2:0] loops;
    logic [3:0] holds;
    logic [31:0] hcnt;
    logic [31:0] bcnt;
    logic bphase;
    logic [7:0] rdata;
    logic [5:0] frame;
    logic mact;
    logic pact;
    logic blink;
    logic fade;
    logic scr;
    logic left;
    logic blk;
    logic [3:0] seg;
    logic done;
  } lmp_st_t;
  lmp_st_t st_ff;
  lmp_st_t nxt_st;
  logic [3:0] seg_w;
  logic ftick;
  lmp_scan #(
    .SEG_CYC(SEG_CYC)
  ) u_scan (
    .clk(clk),
    .sys_rst(sys_rst),
    .scan_limit(st_ff.repeat_scan[3:0]),
    .segment(seg_w),
    .frame_tick(ftick)
  );
  function automatic logic [7:0] rd_mux(input lmp_st_t s, input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == lmp_pkg::ADDR_PICTURE) begin
      r = s.picture;
    end else if (a == lmp_pkg::ADDR_MOVIE) begin
      r = s.movie;
    end else if (a == lmp_pkg::ADDR_PLAYBACK) begin
      r = s.playback;
    end else if (a == lmp_pkg::ADDR_HOLD_SHIFT) begin
      r = s.hold_shift;
    end else if (a == lmp_pkg::ADDR_REPEAT_SCAN) begin
      r = s.repeat_scan;
    end else if (a == lmp_pkg::ADDR_CURRENT) begin
      r = s.current;
    end
    return r;
  endfunction
  logic [2:0] loop_f;
  logic endless;
  logic last_frame;
  logic hold_over;
  logic [31:0] bper;
  logic blink_req;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (reg_wr) begin
      if (reg_addr == lmp_pkg::ADDR_PICTURE) begin
        nxt_st.picture = reg_wdata;
      end else if (reg_addr == lmp_pkg::ADDR_MOVIE) begin
        nxt_st.movie = reg_wdata;
      end else if (reg_addr == lmp_pkg::ADDR_PLAYBACK) begin
        nxt_st.playback = reg_wdata;
      end else if (reg_addr == lmp_pkg::ADDR_HOLD_SHIFT) begin
        nxt_st.hold_shift = reg_wdata;
      end else if (reg_addr == lmp_pkg::ADDR_REPEAT_SCAN) begin
        nxt_st.repeat_scan = reg_wdata;
      end else if (reg_addr == lmp_pkg::ADDR_CURRENT) begin
        nxt_st.current = reg_wdata;
      end
    end
    nxt_st.rdata = rd_mux(st_ff, reg_addr);
    loop_f = st_ff.repeat_scan[7:5];
    endless = (loop_f == lmp_pkg::LOOP_ENDLESS);
    last_frame = (st_ff.pos == st_ff.playback[5:0]);
    hold_over = (st_ff.hcnt >= 32'(HOLD_STEP_CYC - 1));
    case (st_ff.state)
      lmp_pkg::LMP_IDLE: begin
        nxt_st.pos = 6'h00;
        nxt_st.loops = 3'h1;
        if (st_ff.movie[lmp_pkg::BIT_SHOW] && loop_f != lmp_pkg::LOOP_INVALID) begin
          nxt_st.state = lmp_pkg::LMP_SHOW;
        end
      end
      lmp_pkg::LMP_SHOW: begin
        nxt_st.holds = 4'h0;
        nxt_st.hcnt = 32'h0000_0000;
        if (ftick) begin
          nxt_st.state = lmp_pkg::LMP_HOLD;
        end
      end
      lmp_pkg::LMP_HOLD: begin
        nxt_st.hcnt = hold_over ? 32'h0000_0000 : st_ff.hcnt + 32'h0000_0001;
        if (hold_over) begin
          nxt_st.holds = st_ff.holds + 4'h1;
        end
        // Code zero shows the frame once, else code steps of 32.5 ms.
        if (st_ff.hold_shift[3:0] == 4'h0 || (hold_over &&
            st_ff.holds + 4'h1 >= st_ff.hold_shift[3:0])) begin
          nxt_st.state = lmp_pkg::LMP_SHOW;
          if (!last_frame) begin
            nxt_st.pos = st_ff.pos + 6'h01;
          end else if (endless || st_ff.loops < loop_f) begin
            nxt_st.pos = 6'h00;
            nxt_st.loops = endless ? st_ff.loops : st_ff.loops + 3'h1;
          end else begin
            nxt_st.state = lmp_pkg::LMP_DONE;
            // A scrolling movie halts on its first frame unless end-last is set.
            if (st_ff.hold_shift[lmp_pkg::BIT_SCROLL] &&
                !st_ff.playback[lmp_pkg::BIT_END_LAST]) begin
              nxt_st.pos = 6'h00;
            end
          end
        end
        if (!st_ff.movie[lmp_pkg::BIT_SHOW]) begin
          nxt_st.state = lmp_pkg::LMP_IDLE;
        end
      end
      lmp_pkg::LMP_DONE: begin
        nxt_st.done = 1'b1;
        nxt_st.state = lmp_pkg::LMP_IDLE;
        // A host write that sets the start bit in this cycle wins over the auto-clear.
        if (!(reg_wr && reg_addr == lmp_pkg::ADDR_MOVIE)) begin
          nxt_st.movie[lmp_pkg::BIT_SHOW] = 1'b0;
        end
      end
      default: nxt_st.state = lmp_pkg::LMP_IDLE;
    endcase
    if (st_ff.state == lmp_pkg::LMP_SHOW && !st_ff.movie[lmp_pkg::BIT_SHOW]) begin
      nxt_st.state = lmp_pkg::LMP_IDLE;
    end
    bper = st_ff.repeat_scan[lmp_pkg::BIT_BLINK_SLOW] ? 32'(BLINK_SLOW_CYC / 2) :
      32'(BLINK_FAST_CYC / 2);
    if (st_ff.bcnt >= bper - 32'h0000_0001) begin
      nxt_st.bcnt = 32'h0000_0000;
      nxt_st.bphase = ~st_ff.bphase;
    end else begin
      nxt_st.bcnt = st_ff.bcnt + 32'h0000_0001;
    end
    nxt_st.mact = (st_ff.state != lmp_pkg::LMP_IDLE);
    nxt_st.pact = st_ff.picture[lmp_pkg::BIT_SHOW] && !st_ff.movie[lmp_pkg::BIT_SHOW];
    nxt_st.frame = st_ff.movie[lmp_pkg::BIT_SHOW] ? st_ff.movie[5:0] + st_ff.pos :
      st_ff.picture[5:0];
    blink_req = st_ff.movie[lmp_pkg::BIT_SHOW] ? st_ff.movie[lmp_pkg::BIT_PIC_BLINK] :
      st_ff.picture[lmp_pkg::BIT_PIC_BLINK];
    nxt_st.blink = !st_ff.playback[lmp_pkg::BIT_BLINK_OFF] && blink_req && st_ff.bphase;
    nxt_st.fade = st_ff.hold_shift[lmp_pkg::BIT_FADE] &&
      !(st_ff.hold_shift[lmp_pkg::BIT_SCROLL] && st_ff.hold_shift[lmp_pkg::BIT_BLOCK]);
    nxt_st.scr = st_ff.hold_shift[lmp_pkg::BIT_SCROLL];
    nxt_st.left = st_ff.hold_shift[lmp_pkg::BIT_DIR];
    nxt_st.blk = st_ff.hold_shift[lmp_pkg::BIT_BLOCK];
    nxt_st.seg = seg_w;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.picture <= lmp_pkg::RST_PICTURE;
      st_ff.movie <= lmp_pkg::RST_MOVIE;
      st_ff.playback <= lmp_pkg::RST_PLAYBACK;
      st_ff.hold_shift <= lmp_pkg::RST_HOLD_SHIFT;
      st_ff.repeat_scan <= lmp_pkg::RST_REPEAT_SCAN;
      st_ff.current <= lmp_pkg::RST_CURRENT;
      st_ff.state <= lmp_pkg::LMP_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign reg_rdata = st_ff.rdata;
  assign frame_index = st_ff.frame;
  assign movie_active = st_ff.mact;
  assign picture_active = st_ff.pact;
  assign blink_on = st_ff.blink;
  assign fade_en = st_ff.fade;
  assign scroll_en = st_ff.scr;
  assign scroll_left = st_ff.left;
  assign scroll_block = st_ff.blk;
  assign segment_sel = st_ff.seg;
  assign led_current = st_ff.current;
  assign movie_done = st_ff.done;
  a_blink_off: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff.playback[7] |=> !blink_on) else $error("Blink not suppressed.");
  a_fade_block: assert property (@(posedge clk) disable iff (sys_rst)
    (st_ff.hold_shift[5] && st_ff.hold_shift[4]) |=> !fade_en) else $error("Fade in block.");
  a_dir_follow: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 scroll_left == $past(st_ff.hold_shift[6])) else $error("Direction wrong.");
  a_block_follow: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 scroll_block == $past(st_ff.hold_shift[5])) else $error("Block wrong.");
  a_scroll_follow: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 scroll_en == $past(st_ff.hold_shift[4])) else $error("Scroll wrong.");
  a_pos_bound: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff.pos <= st_ff.playback[5:0] || st_ff.state == lmp_pkg::LMP_IDLE)
    else $error("Frame past length.");
  a_endless_run: assert property (@(posedge clk) disable iff (sys_rst)
    (st_ff.state == lmp_pkg::LMP_HOLD && st_ff.repeat_scan[7:5] == 3'h7 && !reg_wr &&
     st_ff.movie[6]) |=> st_ff.state != lmp_pkg::LMP_DONE) else $error("Endless ended.");
  a_movie_prio: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff.movie[6] |=> !picture_active) else $error("Picture over movie.");
endmodule

// ==== bench/lmp_host.sv ====
`timescale 1ns/1ps
module lmp_host (
  input wire logic clk,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One write strobe; the data is scrambled again once the edge has taken it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // Selects an address; its read data is settled when the task returns.
  task automatic sel(input logic [7:0] a);
    @(posedge clk);
    #1;
    reg_addr = a;
    @(posedge clk);
    #1;
  endtask
endmodule

// ==== bench/lmp_ctrl_tb.sv ====
`timescale 1ns/1ps
module lmp_ctrl_tb;
  logic clk, sys_rst, reg_wr, movie_active, picture_active, blink_on, fade_en;
  logic scroll_en, scroll_left, scroll_block, movie_done, prev, dn;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, led_current;
  logic [5:0] frame_index, fst;
  logic [3:0] segment_sel, mx;
  logic [7:0] cfg [4] = '{8'h80, 8'hb0, 8'he0, 8'h50};
  logic [7:0] res [4] = '{8'h08, 8'h05, 8'h0b, 8'h06};
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int t0, t1, n, p;
  lmp_host u_lmp_host (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  lmp_ctrl #(.HOLD_STEP_CYC(48), .BLINK_FAST_CYC(40), .BLINK_SLOW_CYC(80), .SEG_CYC(4))
  u_lmp_ctrl (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame_index(frame_index),
    .movie_active(movie_active), .picture_active(picture_active), .blink_on(blink_on),
    .fade_en(fade_en), .scroll_en(scroll_en), .scroll_left(scroll_left),
    .scroll_block(scroll_block), .segment_sel(segment_sel), .led_current(led_current),
    .movie_done(movie_done));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    u_lmp_host.sel(a);
    chk("reg_rdata", reg_rdata, exp);
  endtask
  // Gap between two rises of the segment-zero slot or of the blink phase.
  task automatic gap(input logic sel);
    logic s;
    int r;
    r = 0;
    p = 0;
    mx = 4'h0;
    prev = 1'b1;
    for (int k = 0; k < 400 && r < 2; k++) begin
      @(posedge clk);
      #2;
      s = sel ? (segment_sel === 4'h0) : (blink_on === 1'b1);
      if (s && !prev) r++;
      if (r == 1) p++;
      if (r == 1 && segment_sel > mx) mx = segment_sel;
      prev = s;
    end
  endtask
  // Optionally starts a movie, then counts frame steps and the length of the second frame.
  task automatic run(input logic [7:0] mv, input int lim);
    logic act;
    logic [5:0] pf;
    act = 1'b0;
    pf = 6'h00;
    t0 = 0;
    n = 0;
    dn = 1'b0;
    fst = 6'h3f;
    if (mv[6]) u_lmp_host.wr(8'h01, mv);
    for (int k = 0; k < lim && dn !== 1'b1; k++) begin
      @(posedge clk);
      #2;
      if (movie_done === 1'b1) dn = 1'b1;
      if (movie_active === 1'b1 && n == 1) t0++;
      if (movie_active === 1'b1 && !act) fst = frame_index;
      if (movie_active === 1'b1 && act && !dn && frame_index !== pf) n++;
      act = (movie_active === 1'b1);
      pf = frame_index;
    end
  endtask
  initial begin
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    for (int a = 0; a < 6; a++) rd(8'(a), (a == 4) ? 8'h20 : 8'h00);
    for (int a = 0; a < 6; a++) u_lmp_host.wr(8'(a), 8'ha5);
    u_lmp_host.wr(8'h10, 8'ha5);
    for (int a = 0; a < 6; a++) rd(8'(a), 8'ha5);
    rd(8'h10, 8'h00);
    chk("led_current", led_current, 8'ha5);
    for (int i = 0; i < 4; i++) begin
      u_lmp_host.wr(8'h03, cfg[i]);
      u_lmp_host.sel(8'h03);
      chk("scroll", {4'h0, fade_en, scroll_en, scroll_left, scroll_block}, res[i]);
    end
    u_lmp_host.wr(8'h04, 8'h22);
    gap(1'b1);
    chk("scan_period", 8'(p), 8'(12));
    chk("scan_max", {4'h0, mx}, 8'h02);
    u_lmp_host.wr(8'h04, 8'h2b);
    gap(1'b1);
    chk("scan_period", 8'(p), 8'(48));
    chk("scan_max", {4'h0, mx}, 8'h0b);
    u_lmp_host.wr(8'h00, 8'hc0);
    u_lmp_host.wr(8'h02, 8'h00);
    gap(1'b0);
    chk("blink_period", 8'(p), 8'(40));
    u_lmp_host.wr(8'h04, 8'h3b);
    gap(1'b0);
    chk("blink_period", 8'(p), 8'(80));
    u_lmp_host.wr(8'h02, 8'h80);
    gap(1'b0);
    chk("blink_off", 8'(p), 8'(0));
    u_lmp_host.wr(8'h00, 8'h40);
    u_lmp_host.wr(8'h02, 8'h02);
    u_lmp_host.wr(8'h03, 8'h00);
    u_lmp_host.wr(8'h04, 8'h2b);
    run(8'h43, 3000);
    t1 = t0;
    chk("movie_done", {7'h0, dn}, 8'h01);
    chk("frame_period", 8'(t1), 8'(48));
    chk("first_frame", {2'b00, fst}, 8'h03);
    chk("frame_steps", 8'(n), 8'h02);
    rd(8'h01, 8'h03);
    u_lmp_host.wr(8'h03, 8'h01);
    run(8'h43, 3000);
    chk("hold_time", 8'(t0 - t1), 8'(48));
    u_lmp_host.wr(8'h03, 8'h00);
    u_lmp_host.wr(8'h04, 8'h4b);
    run(8'h43, 3000);
    chk("loop_steps", 8'(n), 8'h05);
    u_lmp_host.wr(8'h04, 8'h0b);
    run(8'h43, 50);
    chk("loop_zero", {7'h0, movie_active}, 8'h00);
    u_lmp_host.wr(8'h01, 8'h03);
    u_lmp_host.wr(8'h00, 8'h00);
    u_lmp_host.wr(8'h04, 8'h2b);
    u_lmp_host.wr(8'h03, 8'h10);
    run(8'h43, 3000);
    chk("end_first", {2'b00, frame_index}, 8'h03);
    u_lmp_host.wr(8'h02, 8'h42);
    run(8'h43, 3000);
    chk("end_last", {2'b00, frame_index}, 8'h05);
    u_lmp_host.wr(8'h00, 8'h40);
    u_lmp_host.wr(8'h02, 8'h02);
    u_lmp_host.wr(8'h04, 8'heb);
    run(8'h43, 800);
    chk("endless", {6'h0, movie_active, picture_active}, 8'h02);
    u_lmp_host.wr(8'h04, 8'h2b);
    run(8'h03, 3000);
    chk("endless_stop", {7'h0, dn}, 8'h01);
    tally_and_finish();
  end
endmodule
